// File: shared/rcpll_pkg.sv
// constants, codes and carriers for the rc trim / pll / clock select block
// assumes a 100 MHz mclk and 8-bit register data on a plain strobe port
package rcpll_pkg;

    // =======================================================
    // clock and time base
    localparam int MCLK_HZ = 100_000_000;
    localparam int WDT_HZ = 128_000;
    // watchdog oscillator emulated by dividing mclk
    localparam int WDT_DIV = MCLK_HZ / WDT_HZ;
    // reset time-outs in microseconds, ticks round up
    localparam int DLY_S_US = 4100;
    localparam int DLY_L_US = 65000;
    localparam int DLYP_S_US = 4000;
    localparam int DLYP_L_US = 64000;
    localparam int DLY_S_TK = (DLY_S_US * 128 + 999) / 1000;
    localparam int DLY_L_TK = (DLY_L_US * 128 + 999) / 1000;
    localparam int DLYP_S_TK = (DLYP_S_US * 128 + 999) / 1000;
    localparam int DLYP_L_TK = (DLYP_L_US * 128 + 999) / 1000;
    // pll lock interval
    localparam int LOCK_MS = 100;
    localparam int LOCK_CYC = LOCK_MS * (MCLK_HZ / 1000);
    // clock-count delays
    localparam int RST_CK = 14;
    localparam int WAKE_RC_CK = 6;
    localparam int WAKE_PLL_CK = 1024;
    localparam int WAKE_PLL_LONG_CK = 16384;

    // =======================================================
    // register offsets
    localparam logic [7:0] OFS_RC_TRIM = 8'h00;
    localparam logic [7:0] OFS_PLL_CSR = 8'h01;
    localparam logic [7:0] OFS_SYS_DIV = 8'h02;
    localparam logic [7:0] OFS_STATUS = 8'h03;
    // pll control / status bit positions
    localparam int PLL_LOCK_BIT = 0;
    localparam int PLL_ON_BIT = 1;
    localparam int PLL_RATE_BIT = 2;
    // reset values of the system divider field
    localparam logic [3:0] DIV_RST_8 = 4'h3;
    localparam logic [3:0] DIV_RST_1 = 4'h0;
    // clock-source fuse codes
    localparam logic [3:0] SRC_EXT = 4'h0;
    localparam logic [3:0] SRC_PLL_EXT = 4'h1;
    localparam logic [3:0] SRC_RC = 4'h2;
    localparam logic [3:0] SRC_PLL_RC = 4'h3;
    // rank offset of the upper trim range (below 0x7f keeps overlap)
    localparam logic [8:0] RANGE_STEP = 9'h040;

    // fuse bundle
    typedef struct packed {
        logic [3:0] src;
        logic [1:0] startup_fuses;
        logic rst_pin_off;
        logic div8;
    } rcpll_fuse_t;

    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rcpll_bus_t;

    // reset / sleep sequencer
    typedef enum logic [2:0] {
        ST_INIT = 3'b000,
        ST_RCK = 3'b001,
        ST_RWDT = 3'b010,
        ST_RUN = 3'b011,
        ST_SLEEP = 3'b100,
        ST_WAKE = 3'b101
    } rcpll_state_t;

endpackage

// File: hw/rcpll_top.sv
// rc oscillator trim, start-up delays, pll control and clock select
// assumes fuses and calibration byte are static, register port on mclk,
// ext_clk_pin asynchronous to mclk
//
// Operation
// - reset loads factory calibration into trim
// - fuse code 0010 selects internal rc
// - rc wake 6 clocks, reset delays by code
// - reset-pin-off fuse lengthens shortest rc delay
// - trim top bit selects overlapping range
// - low seven bits tune monotonically upward
// - trim is software writable, retunes immediately
// - pll multiplies 1 MHz rc reference by 64
// - pll tracks trim, unlocks above reference
// - enable bit runs pll and rc
// - pll enable reads one when pll clocks system
// - lock flag after lock interval enables fast clock
// - rate bit picks 64 or 32 MHz
// - csr bits 7..3 read zero
// - deep sleep turns off rc reference and pll
// - pll wake 1K/16K, reset delays by code
// - fuse code 0000 selects external clock pin
// - external clock wake 6, reset delays by code
// - reset time-out timed by watchdog oscillator
// - watchdog oscillator runs at 128 kHz
// - divider resets to 0011 with div8 fuse
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps

module rcpll_top
#(
    parameter int LOCK_CYC = rcpll_pkg::LOCK_CYC,
    parameter int DLY_L_TK = rcpll_pkg::DLY_L_TK,
    parameter int DLYP_L_TK = rcpll_pkg::DLYP_L_TK,
    parameter int WAKE_PLL_LONG_CK = rcpll_pkg::WAKE_PLL_LONG_CK
)
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    // register port
    input wire rcpll_pkg::rcpll_bus_t bus,
    output logic [7:0] rdata,
    // fuses and factory calibration byte
    input wire rcpll_pkg::rcpll_fuse_t fuse,
    input wire logic [7:0] cal_byte,
    // sleep control from the power manager
    input wire logic sleep_req,
    input wire logic sleep_deep,
    // external clock pin
    input wire logic ext_clk_pin,
    // oscillator and clock status
    output logic [7:0] rc_trim_out,
    output logic [8:0] rc_freq_rank,
    output logic rc_run,
    output logic pll_run,
    output logic pll_locked_flag,
    output logic pll_saturated,
    output logic fast_periph_en,
    output logic fast_rate_64,
    output logic [3:0] sys_div_field,
    output logic sys_src_ext,
    output logic core_ready,
    output logic wdt_tick,
    output logic ext_clk_edge
);

    // =======================================================
    // state
    rcpll_pkg::rcpll_state_t state;
    rcpll_pkg::rcpll_state_t next_state;
    logic [7:0] rc_trim_reg; // live trim
    logic [7:0] cal_ref; // trim giving the nominal 1 MHz reference
    logic pll_on_bit; // software enable
    logic pll_rate_select; // 1: 64 MHz output
    logic [3:0] div_reg; // system divider field
    logic [15:0] ck_cnt; // clock-count delays
    logic [9:0] wdt_div; // watchdog oscillator emulation
    logic [13:0] wdt_cnt; // watchdog ticks waited
    logic [23:0] lock_cnt; // pll lock interval
    logic lock_done;
    logic [2:0] ext_sync; // [0],[1] synchroniser, [2] history

    // =======================================================
    // source decode
    // rc is system clock on its code
    wire src_rc = fuse.src == rcpll_pkg::SRC_RC;
    wire src_ext = fuse.src == rcpll_pkg::SRC_EXT;
    wire src_pll = (fuse.src == rcpll_pkg::SRC_PLL_RC)
        || (fuse.src == rcpll_pkg::SRC_PLL_EXT);

    // forced enable while pll clocks the system
    wire pll_on_eff = pll_on_bit | src_pll;
    // deep sleep stops reference and pll
    wire deep_off = (state == rcpll_pkg::ST_SLEEP) && sleep_deep;
    // enable starts rc as the pll reference
    wire rc_need = src_rc | pll_on_eff;
    wire next_rc_run = rc_need && !deep_off;
    wire next_pll_run = pll_on_eff && !deep_off;

    // =======================================================
    // trim rank: a monotone stand-in for the rc frequency
    // upper range offset by less than full span
    function automatic logic [8:0] trim_rank(input logic [7:0] t);
        trim_rank = {2'b00, t[6:0]}
            + (t[7] ? rcpll_pkg::RANGE_STEP : 9'h000);
    endfunction

    wire [8:0] rank_now = trim_rank(rc_trim_reg);
    // reference above 1 MHz saturates and unlocks
    wire over_ref = rank_now > trim_rank(cal_ref);

    // =======================================================
    // reset delay selection
    // time-out counted in watchdog ticks
    // programmed reset-pin-off fuse lengthens the shortest rc / external delay
    wire [13:0] tk_none = (!src_pll && fuse.rst_pin_off)
        ? 14'(rcpll_pkg::DLY_S_TK) : 14'h0000;
    // rc / external / pll short delay
    wire [13:0] tk_short = src_pll ? 14'(rcpll_pkg::DLYP_S_TK)
        : 14'(rcpll_pkg::DLY_S_TK);
    // pll long delay, rc and external long delay
    wire [13:0] tk_long = src_pll ? 14'(DLYP_L_TK) : 14'(DLY_L_TK);
    // reserved for rc / external: the longest delay is the safe guess
    wire [13:0] tk_resv = src_pll ? 14'h0000 : 14'(DLY_L_TK);
    wire [13:0] rst_ticks = (fuse.startup_fuses == 2'b00) ? tk_none
        : (fuse.startup_fuses == 2'b01) ? tk_short
        : (fuse.startup_fuses == 2'b10) ? tk_long : tk_resv;

    // wake-up clock count
    // rc wake / external wake / pll wake
    wire [15:0] wake_ck = !src_pll ? 16'(rcpll_pkg::WAKE_RC_CK)
        : (fuse.startup_fuses == 2'b11) ? 16'(WAKE_PLL_LONG_CK)
        : 16'(rcpll_pkg::WAKE_PLL_CK);

    // =======================================================
    // watchdog oscillator tick
    // 128 kHz tick from mclk
    wire wdt_wrap = wdt_div == 10'(rcpll_pkg::WDT_DIV - 1);
    wire [9:0] next_wdt_div = wdt_wrap ? 10'h000 : wdt_div + 10'h001;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wdt_div <= 10'h000;
            wdt_tick <= 1'b0;
        end
        else if (clk_en)
        begin
            wdt_div <= next_wdt_div;
            wdt_tick <= wdt_wrap;
        end
    end

    // =======================================================
    // sequencer: reset delay, run, sleep, wake
    wire ck_done14 = ck_cnt == 16'(rcpll_pkg::RST_CK - 1);
    wire wake_done = ck_cnt == wake_ck - 16'h0001;
    wire wdt_done = wdt_cnt >= rst_ticks;

    always_comb
    begin
        next_state = state;
        unique case (state)
            rcpll_pkg::ST_INIT:
                next_state = rcpll_pkg::ST_RCK;
            rcpll_pkg::ST_RCK:
                if (ck_done14)
                    next_state = rcpll_pkg::ST_RWDT;
            rcpll_pkg::ST_RWDT:
                if (wdt_done)
                    next_state = rcpll_pkg::ST_RUN;
            rcpll_pkg::ST_RUN:
                if (sleep_req)
                    next_state = rcpll_pkg::ST_SLEEP;
            rcpll_pkg::ST_SLEEP:
                if (!sleep_req)
                    next_state = rcpll_pkg::ST_WAKE;
            rcpll_pkg::ST_WAKE:
                if (wake_done)
                    next_state = rcpll_pkg::ST_RUN;
            default:
                next_state = rcpll_pkg::ST_INIT;
        endcase
    end

    // clock count restarts on each state change
    wire state_chg = next_state != state;
    wire [15:0] next_ck_cnt = state_chg ? 16'h0000 : ck_cnt + 16'h0001;
    wire [13:0] next_wdt_cnt = (state != rcpll_pkg::ST_RWDT) ? 14'h0000
        : wdt_tick ? wdt_cnt + 14'h0001 : wdt_cnt;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= rcpll_pkg::ST_INIT;
            ck_cnt <= 16'h0000;
            wdt_cnt <= 14'h0000;
            core_ready <= 1'b0;
        end
        else if (clk_en)
        begin
            state <= next_state;
            ck_cnt <= next_ck_cnt;
            wdt_cnt <= next_wdt_cnt;
            core_ready <= next_state == rcpll_pkg::ST_RUN;
        end
    end

    // =======================================================
    // register port decode
    wire wr_trim = bus.wr && (bus.addr == rcpll_pkg::OFS_RC_TRIM);
    wire wr_csr = bus.wr && (bus.addr == rcpll_pkg::OFS_PLL_CSR);
    wire wr_div = bus.wr && (bus.addr == rcpll_pkg::OFS_SYS_DIV);
    wire init = state == rcpll_pkg::ST_INIT;

    // registers: loaded in the first cycle after reset release so no
    // port value feeds an asynchronous reset
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rc_trim_reg <= 8'h00;
            cal_ref <= 8'h00;
            pll_on_bit <= 1'b0;
            pll_rate_select <= 1'b0;
            div_reg <= 4'h0;
        end
        else if (clk_en)
        begin
            if (init)
            begin
                rc_trim_reg <= cal_byte;
                cal_ref <= cal_byte;
                div_reg <= fuse.div8 ? rcpll_pkg::DIV_RST_8
                    : rcpll_pkg::DIV_RST_1;
            end
            else
            begin
                if (wr_trim)
                    rc_trim_reg <= bus.wdata;
                if (wr_csr)
                begin
                    pll_on_bit <= bus.wdata[rcpll_pkg::PLL_ON_BIT];
                    pll_rate_select <= bus.wdata[rcpll_pkg::PLL_RATE_BIT];
                end
                if (wr_div)
                    div_reg <= bus.wdata[3:0];
            end
        end
    end

    // =======================================================
    // pll lock interval
    // disable or deep sleep restarts the lock interval
    wire lock_wrap = lock_cnt == 24'(LOCK_CYC - 1);
    wire [23:0] next_lock_cnt = !next_pll_run ? 24'h000000
        : lock_done ? lock_cnt : lock_cnt + 24'h000001;
    wire next_lock_done = next_pll_run && (lock_done || lock_wrap);
    // locked after interval / not while saturated
    wire next_locked = next_lock_done && !over_ref;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lock_cnt <= 24'h000000;
            lock_done <= 1'b0;
        end
        else if (clk_en)
        begin
            lock_cnt <= next_lock_cnt;
            lock_done <= next_lock_done;
        end
    end

    // =======================================================
    // read data, valid the cycle after the read strobe
    // upper bits read zero; bit 2 rate, bit 1 enable, bit 0 lock
    // enable reads one under pll system clock
    wire [7:0] rd_csr = {5'b00000, pll_rate_select, pll_on_eff,
        pll_locked_flag};
    wire [7:0] rd_stat = {3'b000, pll_saturated, sys_src_ext, core_ready,
        pll_run, rc_run};
    wire [7:0] rd_mux = (bus.addr == rcpll_pkg::OFS_RC_TRIM) ? rc_trim_reg
        : (bus.addr == rcpll_pkg::OFS_PLL_CSR) ? rd_csr
        : (bus.addr == rcpll_pkg::OFS_SYS_DIV) ? {4'h0, div_reg}
        : (bus.addr == rcpll_pkg::OFS_STATUS) ? rd_stat : 8'h00;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= 8'h00;
        else if (clk_en)
            rdata <= bus.rd ? rd_mux : 8'h00;
    end

    // =======================================================
    // external clock pin: two-flop synchroniser, edge from stage 2/3
    // pin rate limits are the source's duty; only edges are seen
    wire ext_rise = ext_sync[1] && !ext_sync[2];

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ext_sync <= 3'b000;
            ext_clk_edge <= 1'b0;
        end
        else if (clk_en)
        begin
            ext_sync <= {ext_sync[1:0], ext_clk_pin};
            // edges counted only with external source
            ext_clk_edge <= ext_rise && src_ext;
        end
    end

    // =======================================================
    // registered status outputs
    // x64 of the 1 MHz reference; rate bit sets 64 or 32
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rc_trim_out <= 8'h00;
            rc_freq_rank <= 9'h000;
            rc_run <= 1'b0;
            pll_run <= 1'b0;
            pll_locked_flag <= 1'b0;
            pll_saturated <= 1'b0;
            fast_periph_en <= 1'b0;
            fast_rate_64 <= 1'b0;
            sys_div_field <= 4'h0;
            sys_src_ext <= 1'b0;
        end
        else if (clk_en)
        begin
            rc_trim_out <= rc_trim_reg;
            rc_freq_rank <= rank_now;
            rc_run <= next_rc_run;
            pll_run <= next_pll_run;
            // clears at once when enable drops
            pll_locked_flag <= next_locked;
            pll_saturated <= next_pll_run && over_ref;
            fast_periph_en <= next_locked;
            fast_rate_64 <= pll_rate_select;
            sys_div_field <= div_reg;
            sys_src_ext <= src_ext;
        end
    end

endmodule

// File: verif/rcpll_top_asserts.sv
// checker for the rc trim / pll / clock select ports
// assumes a bind onto rcpll_top and one clock domain on mclk
`timescale 1ns/10ps

module rcpll_chk
#(
    parameter int LOCK_CYC = 50
)
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    // register port, fuses and sleep control
    input wire rcpll_pkg::rcpll_bus_t bus,
    input wire logic [7:0] rdata,
    input wire rcpll_pkg::rcpll_fuse_t fuse,
    input wire logic sleep_req,
    input wire logic sleep_deep,
    // status outputs
    input wire logic [7:0] rc_trim_out,
    input wire logic rc_run,
    input wire logic pll_run,
    input wire logic pll_locked_flag,
    input wire logic pll_saturated,
    input wire logic fast_rate_64,
    input wire logic sys_src_ext,
    input wire logic core_ready,
    input wire logic wdt_tick
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // =======================================================
    // helper logic
    int run_cnt; // cycles the pll has been running
    int gap; // cycles since the last watchdog tick
    logic seen; // first tick has no reference point
    logic pll_cfg; // pll clocks the system
    assign pll_cfg = fuse.src == rcpll_pkg::SRC_PLL_RC ||
        fuse.src == rcpll_pkg::SRC_PLL_EXT;

    // counters freeze with clk_en, like the block itself
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            run_cnt <= 0;
            gap <= 0;
            seen <= 1'b0;
        end
        else if (clk_en)
        begin
            run_cnt <= pll_run ? run_cnt + 1 : 0;
            gap <= wdt_tick ? 0 : gap + 1;
            seen <= seen | wdt_tick;
        end
    end

    // =======================================================
    // properties
    property p_csr_res;
        clk_en && bus.rd && bus.addr == rcpll_pkg::OFS_PLL_CSR
            |=> rdata[7:3] == 5'h00;
    endproperty
    a_csr_res: assert property (p_csr_res) else $error("csr high bits");
    property p_on_forced;
        clk_en && bus.rd && bus.addr == rcpll_pkg::OFS_PLL_CSR && pll_cfg
            |=> rdata[1];
    endproperty
    a_on_forced: assert property (p_on_forced) else $error("enable 0");
    property p_lock_late;
        $rose(pll_locked_flag) |-> run_cnt >= LOCK_CYC - 2;
    endproperty
    a_lock_late: assert property (p_lock_late) else $error("early lock");
    property p_lock_off;
        !pll_run |-> !pll_locked_flag;
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock no pll");
    property p_sat;
        pll_saturated |-> !pll_locked_flag;
    endproperty
    a_sat: assert property (p_sat) else $error("lock while saturated");
    property p_tick;
        clk_en && wdt_tick && seen |-> gap == rcpll_pkg::WDT_DIV - 1;
    endproperty
    a_tick: assert property (p_tick) else $error("tick spacing");
    property p_ext_sel;
        core_ready |-> sys_src_ext == (fuse.src == rcpll_pkg::SRC_EXT);
    endproperty
    a_ext_sel: assert property (p_ext_sel) else $error("ext select");
    property p_rate;
        clk_en && core_ready && bus.wr && bus.addr == rcpll_pkg::OFS_PLL_CSR
            |-> ##2 fast_rate_64 == $past(bus.wdata[2], 2);
    endproperty
    a_rate: assert property (p_rate) else $error("rate bit");
    property p_trim;
        clk_en && core_ready && bus.wr && bus.addr == rcpll_pkg::OFS_RC_TRIM
            |-> ##2 rc_trim_out == $past(bus.wdata, 2);
    endproperty
    a_trim: assert property (p_trim) else $error("trim write");
    property p_deep;
        $fell(core_ready) && sleep_req && sleep_deep
            |-> ##[0:3] (!rc_run && !pll_run);
    endproperty
    a_deep: assert property (p_deep) else $error("deep sleep runs");
endmodule

bind rcpll_top rcpll_chk #(.LOCK_CYC(LOCK_CYC)) rcpll_chk_i (
    .mclk, .rst_b, .clk_en, .bus, .rdata, .fuse, .sleep_req, .sleep_deep,
    .rc_trim_out, .rc_run, .pll_run, .pll_locked_flag, .pll_saturated,
    .fast_rate_64, .sys_src_ext, .core_ready, .wdt_tick);

// File: verif/rcpll_ext_src.sv
// external clock source on the clock input pin
// assumes the bench starts it only around a reset
`timescale 1ns/10ps

module rcpll_ext_src
#(
    parameter int HALF_NS = 37
)
(
    // control
    input wire logic run,
    // pin
    output logic ext_clk_pin
);
    // =======================================================
    // fixed period, so no step between cycles; rests low when off
    // steady frequency
    initial
    begin
        ext_clk_pin = 1'b0;
        forever
        begin
            #HALF_NS;
            ext_clk_pin = run ? ~ext_clk_pin : 1'b0;
        end
    end
endmodule

// File: verif/rcpll_top_tb.sv
// bench for the rc trim / pll / clock select block
// assumes shortened counts and a 100 MHz mclk
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end

module rcpll_top_tb;
    localparam int LK = 50; // shortened lock interval
    localparam int WD = rcpll_pkg::WDT_DIV; // mclk per watchdog tick
    localparam logic [7:0] TV [6] = '{8'h00, 8'h01, 8'h3f, 8'h7f, 8'h80,
        8'hff};
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    rcpll_pkg::rcpll_bus_t bus = '0;
    rcpll_pkg::rcpll_fuse_t fuse = '0;
    logic [7:0] cal_byte = 8'h00;
    logic sleep_req = 1'b0;
    logic sleep_deep = 1'b0;
    logic run_ext = 1'b0; // partner clock on/off
    logic ext_clk_pin, rc_run, pll_run, pll_locked_flag, pll_saturated;
    logic fast_periph_en, fast_rate_64, sys_src_ext, core_ready, wdt_tick;
    logic ext_clk_edge;
    logic [7:0] rdata, rc_trim_out, d;
    logic [8:0] rc_freq_rank, er, pr;
    logic [3:0] sys_div_field;
    int mismatches = 0;
    int checked = 0;
    int n, k;

    // =======================================================
    // clock, partner, design
    always #5 mclk = ~mclk;
    rcpll_ext_src rcpll_ext_src_i (.run(run_ext), .ext_clk_pin);
    rcpll_top #(.LOCK_CYC(LK), .DLY_L_TK(20), .DLYP_L_TK(20),
        .WAKE_PLL_LONG_CK(40)) rcpll_top_i (
        .mclk, .rst_b, .clk_en, .bus, .rdata, .fuse, .cal_byte, .sleep_req,
        .sleep_deep, .ext_clk_pin, .rc_trim_out, .rc_freq_rank, .rc_run,
        .pll_run, .pll_locked_flag, .pll_saturated, .fast_periph_en,
        .fast_rate_64, .sys_div_field, .sys_src_ext, .core_ready,
        .wdt_tick, .ext_clk_edge);

    // =======================================================
    // tasks
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        bus <= '{1'b1, 1'b0, a, v};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 d = rdata;
        `CHK(d, e)
    endtask
    // bounded wait on ready (sel 0) or lock (sel 1)
    task automatic wt(input bit sel, input int lim);
        n = 0;
        while ((sel ? pll_locked_flag : core_ready) !== 1'b1 && n < lim)
            @(posedge mclk) #1 n++;
        if (n >= lim)
        begin
            mismatches++;
            print_verdict();
        end
    endtask
    // fuses only change while reset is held
    task automatic rst(input rcpll_pkg::rcpll_fuse_t f, input logic [7:0] c);
        @(posedge mclk);
        rst_b <= 1'b0;
        fuse <= f;
        cal_byte <= c;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
    endtask

    // =======================================================
    // main sequence
    initial
    begin
        rst('{rcpll_pkg::SRC_RC, 2'b00, 1'b0, 1'b1}, 8'h9a);
        wt(0, 100);
        `CHK(n >= 14 && n <= 18, 1'b1)
        rc(rcpll_pkg::OFS_RC_TRIM, 8'h9a);
        rc(rcpll_pkg::OFS_SYS_DIV, 8'h03);
        rc(rcpll_pkg::OFS_PLL_CSR, 8'h00);
        rc(8'h07, 8'h00);
        rc(rcpll_pkg::OFS_STATUS, 8'h05);
        `CHK({rc_run, sys_src_ext}, 2'b10)
        foreach (TV[i])
        begin
            er = {2'b00, TV[i][6:0]} + (TV[i][7] ? 9'h040 : 9'h000);
            wr(rcpll_pkg::OFS_RC_TRIM, TV[i]);
            repeat (2) @(posedge mclk);
            #1 `CHK(rc_freq_rank, er)
            if (TV[i] == 8'h80)
                `CHK(rc_freq_rank < pr, 1'b1)
            pr = rc_freq_rank;
            rc(rcpll_pkg::OFS_RC_TRIM, TV[i]);
        end
        // frozen clock enable must drop the write
        @(posedge mclk);
        clk_en <= 1'b0;
        wr(rcpll_pkg::OFS_RC_TRIM, 8'h11);
        @(posedge mclk);
        clk_en <= 1'b1;
        rc(rcpll_pkg::OFS_RC_TRIM, 8'hff);
        wr(rcpll_pkg::OFS_RC_TRIM, 8'h9a);
        wr(rcpll_pkg::OFS_PLL_CSR, 8'h06);
        wt(1, 200);
        `CHK(n >= LK - 2 && n <= LK + 4, 1'b1)
        `CHK({fast_periph_en, fast_rate_64, pll_run, rc_run}, 4'hf)
        rc(rcpll_pkg::OFS_PLL_CSR, 8'h07);
        wr(rcpll_pkg::OFS_PLL_CSR, 8'h02);
        rc(rcpll_pkg::OFS_PLL_CSR, 8'h03);
        // one trim step above factory pushes the pll out of lock
        wr(rcpll_pkg::OFS_RC_TRIM, 8'h9b);
        repeat (3) @(posedge mclk);
        #1 `CHK({pll_saturated, pll_locked_flag}, 2'b10)
        wr(rcpll_pkg::OFS_RC_TRIM, 8'h9a);
        wr(rcpll_pkg::OFS_PLL_CSR, 8'h00);
        @(posedge mclk) #1 `CHK(pll_locked_flag, 1'b0)
        wr(rcpll_pkg::OFS_PLL_CSR, 8'h02);
        repeat (10) @(posedge mclk);
        #1 `CHK(pll_locked_flag, 1'b0)
        wt(1, 200);
        @(posedge mclk);
        sleep_deep <= 1'b1;
        sleep_req <= 1'b1;
        repeat (5) @(posedge mclk);
        #1 `CHK({rc_run, pll_run, pll_locked_flag}, 3'b000)
        @(posedge mclk);
        sleep_req <= 1'b0;
        wt(0, 50);
        `CHK(n >= 5 && n <= 10, 1'b1)
        `CHK(pll_locked_flag, 1'b0)
        // external clock, long start-up timed by the watchdog ticks
        run_ext <= 1'b1;
        rst('{rcpll_pkg::SRC_EXT, 2'b10, 1'b0, 1'b0}, 8'h40);
        wt(0, 20000);
        `CHK(n >= 15 + 19 * WD && n <= 20 + 21 * WD, 1'b1)
        `CHK({sys_src_ext, sys_div_field}, 5'h10)
        k = 0;
        repeat (1000) @(posedge mclk) #1 k += int'(ext_clk_edge);
        `CHK(k >= 133 && k <= 137, 1'b1)
        rst('{rcpll_pkg::SRC_PLL_RC, 2'b11, 1'b0, 1'b0}, 8'h9a);
        wt(0, 100);
        `CHK(n >= 14 && n <= 18, 1'b1)
        wr(rcpll_pkg::OFS_PLL_CSR, 8'h00);
        rc(rcpll_pkg::OFS_PLL_CSR, 8'h02);
        @(posedge mclk);
        sleep_deep <= 1'b0;
        sleep_req <= 1'b1;
        repeat (4) @(posedge mclk);
        sleep_req <= 1'b0;
        wt(0, 100);
        `CHK(n >= 39 && n <= 44, 1'b1)
        rst('{rcpll_pkg::SRC_RC, 2'b00, 1'b1, 1'b0}, 8'h9a);
        repeat (300) @(posedge mclk);
        #1 `CHK({core_ready, sys_div_field}, 5'h00)
        print_verdict();
    end
endmodule
